// ==== hdl/ftx_pkg.sv ====
package ftx_pkg;
    // Register offsets (byte-wide registers on a plain port)
    localparam logic [6:0] FTX_ADDR_MAIN = 7'h00;
    localparam logic [6:0] FTX_ADDR_MODIND = 7'h01;
    localparam logic [6:0] FTX_ADDR_FILTCUR = 7'h04;
    localparam logic [6:0] FTX_ADDR_ATTEN = 7'h05;
    localparam logic [6:0] FTX_ADDR_CLKSHIFT = 7'h06;
    localparam logic [6:0] FTX_ADDR_RATEDIV = 7'h07;
    localparam logic [6:0] FTX_ADDR_STATUS = 7'h08;
    // Field positions
    localparam int FTX_PA_LSB = 4;
    localparam int FTX_MODE_LSB = 1;
    localparam int FTX_MODTYPE_LSB = 6;
    localparam int FTX_WCS_LSB = 4;
    localparam int FTX_REFK_LSB = 0;
    // Reset values
    localparam logic [7:0] FTX_RST_MAIN = 8'h00;
    localparam logic [7:0] FTX_RST_MODIND = 8'h00;
    localparam logic [7:0] FTX_RST_FILTCUR = 8'h00;
    localparam logic [7:0] FTX_RST_ATTEN = 8'h10;
    localparam logic [7:0] FTX_RST_CLKSHIFT = 8'h00;
    localparam logic [7:0] FTX_RST_RATEDIV = 8'h01;
    // Attenuator register fixed bits
    localparam logic [7:0] FTX_ATTEN_FIXED = 8'h10;
    // Edge timing: modulator clock periods per transition
    localparam int FTX_EDGE_PERIODS = 4;
    // Modulation types
    typedef enum logic [1:0] {
        FTX_MOD_WAVE = 2'b00,
        FTX_MOD_UNUSED1 = 2'b01,
        FTX_MOD_DIVSET = 2'b10,
        FTX_MOD_UNUSED3 = 2'b11
    } ftx_modtype_type;
    // Transceiver modes (main control, bits 2:1)
    localparam logic [1:0] FTX_MODE_TX = 2'b10;
endpackage : ftx_pkg

// ==== hdl/ftx_fifo_if.sv ====
`timescale 1ns/1ps
interface ftx_fifo_if #(parameter int WIDTH = 2);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : ftx_fifo_if

// ==== hdl/ftx_fifo.sv ====
`timescale 1ns/1ps
module ftx_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    ftx_fifo_if.fifo port // Both handshake sides
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two, at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Honest flags straight from the fill count
    assign port.in_ready = (count != (AW+1)'(DEPTH));
    assign port.out_valid = (count != '0);
    assign port.out_data = mem[rd_ptr];
    assign push = port.in_valid && port.in_ready;
    assign pop = port.out_valid && port.out_ready;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= port.in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end

    // Fill level never passes the depth
    property p_no_overflow;
        @(posedge clk) disable iff (!rst_n)
        count <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("FIFO fill above depth");
endmodule : ftx_fifo

// ==== hdl/ftx_tx_ctrl.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module ftx_tx_ctrl
    import ftx_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic CORE_CLK, // Crystal-derived core clock
    input wire logic RESETN, // Async reset, active low
    input wire logic [6:0] ADDR, // Register address
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [7:0] RDATA, // Read data, cycle after RD
    input wire logic DATA_PIN_I, // Data pin level seen
    input wire logic DATA_PIN_DRIVEN, // Data pin driven by controller
    output logic DATA_PIN_O, // Data pin drive value
    output logic DATA_PIN_OE, // Data pin output enable
    input wire logic RX_DATA, // Received data from demodulator
    input wire logic PLL_LOCK, // Synthesizer lock indication
    output logic AMP_ON, // Amplifier enable
    output logic [2:0] AMP_LEVEL, // Amplifier level code
    output logic DIV_SET_ONE, // Synthesizer uses divider set one
    output logic MOD_CLK_TICK, // One-cycle modulator clock tick
    output logic [1:0] WAVE_PHASE, // Edge period index 0..3
    output logic WAVE_ACTIVE, // Waveform edge in progress
    output logic [1:0] WAVE_TARGET // 00 centre, 01 up, 10 down
);
    ftx_modtype_type mod_type;
    logic [7:0] reg_main;
    logic [7:0] reg_modind;
    logic [7:0] reg_filtcur;
    logic [7:0] reg_atten;
    logic [7:0] reg_clkshift;
    logic [7:0] reg_ratediv;
    logic [2:0] amp_power_level;
    logic tx_mode;
    logic [2:0] waveform_clock_shift;
    logic [5:0] ref_div;
    logic [5:0] ref_cnt;
    logic [6:0] pow_cnt;
    logic ref_tick;
    logic [1:0] sym_code;
    logic [1:0] cur_level;
    logic [1:0] edge_cnt;
    logic fifo_ovf;

    ftx_fifo_if #(.WIDTH(2)) sym_if();

    assign amp_power_level = reg_main[FTX_PA_LSB +: 3];
    assign tx_mode = (reg_main[FTX_MODE_LSB +: 2] == FTX_MODE_TX);
    assign mod_type = ftx_modtype_type'(reg_modind[FTX_MODTYPE_LSB +: 2]);
    assign waveform_clock_shift = reg_clkshift[FTX_WCS_LSB +: 3];
    assign ref_div = reg_ratediv[FTX_REFK_LSB +: 6];

    // Register writes; reserved attenuator bits stay at their fixed pattern
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            reg_main <= FTX_RST_MAIN;
            reg_modind <= FTX_RST_MODIND;
            reg_filtcur <= FTX_RST_FILTCUR;
            reg_atten <= FTX_RST_ATTEN;
            reg_clkshift <= FTX_RST_CLKSHIFT;
            reg_ratediv <= FTX_RST_RATEDIV;
        end else if (WR) begin
            if (ADDR == FTX_ADDR_MAIN) begin
                reg_main <= WDATA;
            end else if (ADDR == FTX_ADDR_MODIND) begin
                reg_modind <= {WDATA[7:6], 1'b0, WDATA[4:0]};
            end else if (ADDR == FTX_ADDR_FILTCUR) begin
                reg_filtcur <= WDATA;
            end else if (ADDR == FTX_ADDR_ATTEN) begin
                reg_atten <= {FTX_ATTEN_FIXED[7:4], WDATA[3:0]};
            end else if (ADDR == FTX_ADDR_CLKSHIFT) begin
                reg_clkshift <= {1'b0, WDATA[6:0]};
            end else if (ADDR == FTX_ADDR_RATEDIV) begin
                reg_ratediv <= WDATA;
            end
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            if (ADDR == FTX_ADDR_MAIN) RDATA <= reg_main;
            else if (ADDR == FTX_ADDR_MODIND) RDATA <= reg_modind;
            else if (ADDR == FTX_ADDR_FILTCUR) RDATA <= reg_filtcur;
            else if (ADDR == FTX_ADDR_ATTEN) RDATA <= reg_atten;
            else if (ADDR == FTX_ADDR_CLKSHIFT) RDATA <= reg_clkshift;
            else if (ADDR == FTX_ADDR_RATEDIV) RDATA <= reg_ratediv;
            else if (ADDR == FTX_ADDR_STATUS) begin
                RDATA <= {2'h0, PLL_LOCK, fifo_ovf, cur_level, AMP_ON, DIV_SET_ONE};
            end else RDATA <= 8'h00;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Amplifier: code 0 is off, 1..7 on in transmit mode with 1 strongest
    assign AMP_ON = tx_mode && (amp_power_level != 3'h0);
    assign AMP_LEVEL = amp_power_level;

    // Data pin: input while transmitting, drives received data otherwise
    assign DATA_PIN_OE = !tx_mode;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) DATA_PIN_O <= 1'b0;
        else DATA_PIN_O <= RX_DATA;
    end

    // Divider set choice; floating pin falls back to set zero
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            DIV_SET_ONE <= 1'b0;
        end else if (tx_mode && mod_type == FTX_MOD_DIVSET) begin
            DIV_SET_ONE <= DATA_PIN_DRIVEN && DATA_PIN_I;
        end else begin
            DIV_SET_ONE <= 1'b0;
        end
    end

    // Modulator clock: ref divider then 2^(7-shift); a zero divider acts as one
    assign ref_tick = (ref_cnt == 6'h00);
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ref_cnt <= 6'h00;
            pow_cnt <= 7'h00;
            MOD_CLK_TICK <= 1'b0;
        end else begin
            ref_cnt <= ref_tick ? ((ref_div == 6'h00) ? 6'h00 : ref_div - 6'h01) : ref_cnt - 6'h01;
            MOD_CLK_TICK <= 1'b0;
            if (ref_tick) begin
                if (pow_cnt == 7'h00) begin
                    pow_cnt <= 7'((8'h80 >> waveform_clock_shift) - 8'h01);
                    MOD_CLK_TICK <= 1'b1;
                end else begin
                    pow_cnt <= pow_cnt - 7'h01;
                end
            end
        end
    end

    // Waveform targets queued; a slow edge can overflow the queue
    // Code: 00 centre (pin floating), 01 up (high), 10 down (low)
    assign sym_code = !DATA_PIN_DRIVEN ? 2'b00 : (DATA_PIN_I ? 2'b01 : 2'b10);
    logic [1:0] last_code;
    logic wave_en;
    assign wave_en = tx_mode && mod_type == FTX_MOD_WAVE;
    // Offer a code only when the pin level differs from the last queued one
    assign sym_if.in_valid = wave_en && (sym_code != last_code);
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            last_code <= 2'b00;
            fifo_ovf <= 1'b0;
        end else begin
            if (wave_en && sym_code != last_code) begin
                if (sym_if.in_ready) last_code <= sym_code;
                else fifo_ovf <= 1'b1;
            end
            if (RD && ADDR == FTX_ADDR_STATUS) fifo_ovf <= 1'b0;
            if (wave_en && sym_code != last_code && !sym_if.in_ready) fifo_ovf <= 1'b1;
        end
    end
    assign sym_if.in_data = sym_code;

    ftx_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .port(sym_if)
    );

    // Edge engine: each transition takes four modulator periods
    assign sym_if.out_ready = !WAVE_ACTIVE && wave_en;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cur_level <= 2'b00;
            WAVE_TARGET <= 2'b00;
            WAVE_ACTIVE <= 1'b0;
            edge_cnt <= 2'h0;
        end else if (!wave_en) begin
            cur_level <= 2'b00;
            WAVE_TARGET <= 2'b00;
            WAVE_ACTIVE <= 1'b0;
            edge_cnt <= 2'h0;
        end else if (!WAVE_ACTIVE) begin
            if (sym_if.out_valid && sym_if.out_data != cur_level) begin
                WAVE_TARGET <= sym_if.out_data;
                WAVE_ACTIVE <= 1'b1;
                edge_cnt <= 2'h0;
            end
        end else if (MOD_CLK_TICK) begin
            if (edge_cnt == 2'(FTX_EDGE_PERIODS - 1)) begin
                WAVE_ACTIVE <= 1'b0;
                cur_level <= WAVE_TARGET;
                edge_cnt <= 2'h0;
            end else begin
                edge_cnt <= edge_cnt + 2'h1;
            end
        end
    end
    // Phase index selects the unequal charge current of each period
    assign WAVE_PHASE = edge_cnt;

    // Helper: modulator ticks seen during the current edge
    logic [2:0] tick_seen;
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) tick_seen <= 3'h0;
        else if (!WAVE_ACTIVE) tick_seen <= 3'h0;
        else if (MOD_CLK_TICK) tick_seen <= tick_seen + 3'h1;
    end

    // Level code zero keeps the amplifier dark
    property p_amp_off;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (amp_power_level == 3'h0) |-> !AMP_ON;
    endproperty
    a_amp_off: assert property (p_amp_off) else $error("Amp on at level zero");

    // Any nonzero level lights the amplifier in transmit
    property p_amp_lit;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (tx_mode && amp_power_level != 3'h0) |-> AMP_ON;
    endproperty
    a_amp_lit: assert property (p_amp_lit) else $error("Amp off at nonzero level");

    // Driven pin picks the divider set one cycle later
    property p_div_follow;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (tx_mode && mod_type == FTX_MOD_DIVSET && DATA_PIN_DRIVEN)
        |=> (DIV_SET_ONE == $past(DATA_PIN_I));
    endproperty
    a_div_follow: assert property (p_div_follow) else $error("Divider set wrong");

    // Released pin falls back to set zero
    property p_div_float;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !DATA_PIN_DRIVEN |=> !DIV_SET_ONE;
    endproperty
    a_div_float: assert property (p_div_float) else $error("Float not set zero");

    // Pin direction follows the transceiver mode
    property p_pin_dir;
        @(posedge CORE_CLK) disable iff (!RESETN)
        DATA_PIN_OE == (reg_main[2:1] != FTX_MODE_TX);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("Pin direction");

    // Edge engine idles outside waveform mode
    property p_wave_only;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (mod_type != FTX_MOD_WAVE) |=> !WAVE_ACTIVE;
    endproperty
    a_wave_only: assert property (p_wave_only) else $error("Wave outside mode");

    // A finished edge has used exactly four ticks
    property p_edge_len;
        @(posedge CORE_CLK) disable iff (!RESETN)
        ($fell(WAVE_ACTIVE) && wave_en) |-> ($past(tick_seen) == 3'(FTX_EDGE_PERIODS - 1));
    endproperty
    a_edge_len: assert property (p_edge_len) else $error("Edge not four periods");

    // Phase index rests at zero between edges
    property p_phase_idle;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !WAVE_ACTIVE |-> (WAVE_PHASE == 2'h0);
    endproperty
    a_phase_idle: assert property (p_phase_idle) else $error("Phase not idle");

    // Leaving waveform mode returns the carrier to centre
    property p_centre_idle;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !wave_en |=> (cur_level == 2'b00);
    endproperty
    a_centre_idle: assert property (p_centre_idle) else $error("Carrier not at LO");

    // Shift seven with divider one ticks every cycle
    property p_tick_shift7;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (MOD_CLK_TICK && waveform_clock_shift == 3'h7 && ref_div == 6'h01
        && $stable(reg_clkshift) && $stable(reg_ratediv)) |=> MOD_CLK_TICK;
    endproperty
    a_tick_shift7: assert property (p_tick_shift7) else $error("Shift 7 not full rate");

    // Read data stand only in the cycle after a strobe
    property p_rdata_idle;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !RD |=> (RDATA == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside slot");

    // A refused level change always raises the sticky flag
    property p_ovf_set;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (sym_if.in_valid && !sym_if.in_ready) |=> fifo_ovf;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("Overflow not flagged");
endmodule : ftx_tx_ctrl

// ==== bench/ftx_host_model.sv ====
`timescale 1ns/1ps
// Host controller: drives the data line in elements of fixed length
module ftx_host_model #(
    parameter int ELEM_CYCLES = 16
) (
    input wire logic clk, // Core clock
    input wire logic amp_on, // Amplifier enable seen
    input wire logic pll_lock, // Synthesizer lock seen
    output logic pin_level, // Level on the data line
    output logic pin_driven // High while the host drives the line
);
    logic last_level;
    logic flag_a; // Last 000 or 111 group used word A
    initial begin
        pin_level = 1'b1;
        pin_driven = 1'b0;
        last_level = 1'b0;
        flag_a = 1'b0;
    end
    // Released line shows the inverse of the last level, not a helpful copy
    task automatic release_line();
        @(posedge clk);
        pin_driven <= 1'b0;
        pin_level <= ~last_level;
    endtask : release_line
    // No element leaves the host before lock and amplifier on
    task automatic drive_elem(input logic b);
        while (!(pll_lock && amp_on)) @(posedge clk);
        @(posedge clk);
        pin_driven <= 1'b1;
        pin_level <= b;
        last_level = b;
        repeat (ELEM_CYCLES - 1) @(posedge clk);
    endtask : drive_elem
    // Data 0 goes out as 10, data 1 as 01
    task automatic send_manch(input logic d);
        drive_elem(~d);
        drive_elem(d);
    endtask : send_manch
    // Three bits to a four-bit word, balanced except 000 and 111 which alternate two words, most significant element first
    task automatic send_3b4b(input logic [2:0] g);
        logic [3:0] w;
        case (g)
            3'b000: w = flag_a ? 4'h4 : 4'hB;
            3'b001: w = 4'hC;
            3'b010: w = 4'h3;
            3'b011: w = 4'hA;
            3'b100: w = 4'h5;
            3'b101: w = 4'h9;
            3'b110: w = 4'h6;
            default: w = flag_a ? 4'h2 : 4'hD;
        endcase
        if (g == 3'b000 || g == 3'b111) flag_a = ~flag_a;
        for (int i = 3; i >= 0; i--) drive_elem(w[i]);
    endtask : send_3b4b
endmodule : ftx_host_model

// ==== bench/tb_fsk_tx_modulation_control.sv ====
`timescale 1ns/1ps
module tb_fsk_tx_modulation_control import ftx_pkg::*;;
    localparam int LIMIT = 60000; // Cycle ceiling, well above the expected run
    localparam logic [6:0] RA [7] = '{7'h00, 7'h01, 7'h04, 7'h05, 7'h06, 7'h07, 7'h02};
    localparam logic [7:0] RE [7] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00};
    localparam logic [6:0] WA [3] = '{7'h01, 7'h05, 7'h06};
    localparam logic [7:0] WE [3] = '{8'hDF, 8'h1F, 8'h7F};
    logic CORE_CLK, RESETN, WR, RD, RX_DATA, PLL_LOCK, DATA_PIN_I, DATA_PIN_DRIVEN;
    logic DATA_PIN_O, DATA_PIN_OE, AMP_ON, DIV_SET_ONE, MOD_CLK_TICK, WAVE_ACTIVE;
    logic [6:0] ADDR;
    logic [7:0] WDATA, RDATA, rv;
    logic [2:0] AMP_LEVEL;
    logic [1:0] WAVE_PHASE, WAVE_TARGET;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    ftx_tx_ctrl ftx_tx_ctrl_inst (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DATA_PIN_I(DATA_PIN_I),
        .DATA_PIN_DRIVEN(DATA_PIN_DRIVEN), .DATA_PIN_O(DATA_PIN_O), .DATA_PIN_OE(DATA_PIN_OE),
        .RX_DATA(RX_DATA), .PLL_LOCK(PLL_LOCK), .AMP_ON(AMP_ON), .AMP_LEVEL(AMP_LEVEL),
        .DIV_SET_ONE(DIV_SET_ONE), .MOD_CLK_TICK(MOD_CLK_TICK), .WAVE_PHASE(WAVE_PHASE),
        .WAVE_ACTIVE(WAVE_ACTIVE), .WAVE_TARGET(WAVE_TARGET));
    ftx_host_model #(.ELEM_CYCLES(16)) ftx_host_model_inst (.clk(CORE_CLK), .amp_on(AMP_ON),
        .pll_lock(PLL_LOCK), .pin_level(DATA_PIN_I), .pin_driven(DATA_PIN_DRIVEN));
    // 200 MHz core clock
    initial begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end
    // A hang counts as a mismatch and ends the run
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            results();
        end
    end
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    // Skip a partial period, then count cycles between two ticks
    task tick_gap(input int exp);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge CORE_CLK);
                n++;
            end while (MOD_CLK_TICK !== 1'b1 && n < 20000);
        end
        chk("tick period", 8'(n), 8'(exp));
    endtask : tick_gap
    task t_regs();
        for (int i = 0; i < 7; i++) begin
            rd(RA[i], rv);
            chk("reset value", rv, RE[i]);
        end
        for (int i = 0; i < 3; i++) begin
            wr(WA[i], 8'hFF);
            rd(WA[i], rv);
            chk("read back", rv, WE[i]);
        end
        $display("register test done");
    endtask : t_regs
    task t_amp();
        for (int l = 0; l < 8; l++) begin
            wr(FTX_ADDR_MAIN, 8'(l << 4) | 8'h04);
            @(negedge CORE_CLK);
            chk("amp on", 8'(AMP_ON), 8'(l != 0));
            chk("amp level", 8'(AMP_LEVEL), 8'(l));
            chk("pin enable in tx", 8'(DATA_PIN_OE), 8'h00);
        end
        wr(FTX_ADDR_MAIN, 8'h10);
        for (int b = 1; b >= 0; b--) begin
            RX_DATA <= b[0];
            repeat (3) @(posedge CORE_CLK);
            @(negedge CORE_CLK);
            chk("pin enable in rx", 8'(DATA_PIN_OE), 8'h01);
            chk("received data out", 8'(DATA_PIN_O), 8'(b));
        end
        wr(FTX_ADDR_MAIN, 8'h14);
        $display("amplifier and pin test done");
    endtask : t_amp
    task t_divset();
        for (int t = 0; t < 4; t++) begin
            wr(FTX_ADDR_MODIND, 8'(t << 6));
            ftx_host_model_inst.drive_elem(1'b1);
            @(negedge CORE_CLK);
            chk("divider set per type", 8'(DIV_SET_ONE), 8'(t == 2));
        end
        wr(FTX_ADDR_MODIND, 8'h80);
        ftx_host_model_inst.drive_elem(1'b0);
        @(negedge CORE_CLK);
        chk("divider set for zero", 8'(DIV_SET_ONE), 8'h00);
        ftx_host_model_inst.drive_elem(1'b1);
        @(negedge CORE_CLK);
        chk("divider set for one", 8'(DIV_SET_ONE), 8'h01);
        ftx_host_model_inst.release_line();
        repeat (4) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        chk("divider set released", 8'(DIV_SET_ONE), 8'h00);
        $display("divider set test done");
    endtask : t_divset
    // Host keeps the line released until lock and amplifier on
    task t_lock();
        PLL_LOCK <= 1'b0;
        rd(FTX_ADDR_STATUS, rv);
        chk("lock status low", 8'(rv[5]), 8'h00);
        chk("status set zero", 8'(rv[0]), 8'h00);
        fork
            ftx_host_model_inst.drive_elem(1'b1);
            begin
                repeat (40) @(posedge CORE_CLK);
                chk("line held released", 8'(DATA_PIN_DRIVEN), 8'h00);
                PLL_LOCK <= 1'b1;
            end
        join
        chk("line driven after lock", 8'(DATA_PIN_DRIVEN), 8'h01);
        rd(FTX_ADDR_STATUS, rv);
        chk("lock status high", 8'(rv[5]), 8'h01);
        chk("status set one", 8'(rv[0]), 8'h01);
        ftx_host_model_inst.release_line();
        $display("lock hold test done");
    endtask : t_lock
    task t_wave();
        wr(FTX_ADDR_MODIND, 8'h00);
        wr(FTX_ADDR_RATEDIV, 8'h03);
        wr(FTX_ADDR_CLKSHIFT, 8'h60);
        tick_gap(6);
        wr(FTX_ADDR_RATEDIV, 8'h02);
        wr(FTX_ADDR_CLKSHIFT, 8'h70);
        tick_gap(2); // Eight ticks per 16-cycle element
        ftx_host_model_inst.release_line();
        repeat (100) @(posedge CORE_CLK);
        fork
            ftx_host_model_inst.send_manch(1'b0);
            begin
                n = 0;
                while (WAVE_ACTIVE !== 1'b1 && n < 200) begin
                    @(negedge CORE_CLK);
                    n++;
                end
                chk("edge target up", 8'(WAVE_TARGET), 8'h01);
                n = 0;
                while (WAVE_ACTIVE === 1'b1 && cycles < LIMIT) begin
                    if (MOD_CLK_TICK === 1'b1) begin
                        chk("edge phase", 8'(WAVE_PHASE), 8'(n));
                        n++;
                    end
                    @(negedge CORE_CLK);
                end
                chk("ticks per edge", 8'(n), 8'(FTX_EDGE_PERIODS));
            end
        join
        chk("edge target down", 8'(WAVE_TARGET), 8'h02);
        ftx_host_model_inst.release_line();
        repeat (30) @(posedge CORE_CLK);
        chk("target centre", 8'(WAVE_TARGET), 8'h00);
        // Slow modulator clock so level changes pile up past the queue depth
        wr(FTX_ADDR_RATEDIV, 8'h3F);
        wr(FTX_ADDR_CLKSHIFT, 8'h00);
        repeat (6) ftx_host_model_inst.send_3b4b(3'b000);
        rd(FTX_ADDR_STATUS, rv);
        chk("overflow set", 8'(rv[4]), 8'h01);
        // A refused change stays pending, so the flag re-sets until room appears
        wr(FTX_ADDR_RATEDIV, 8'h01);
        wr(FTX_ADDR_CLKSHIFT, 8'h70);
        ftx_host_model_inst.release_line();
        repeat (500) @(posedge CORE_CLK);
        chk("queue drained", 8'(WAVE_ACTIVE), 8'h00);
        chk("drained target", 8'(WAVE_TARGET), 8'h00);
        rd(FTX_ADDR_STATUS, rv);
        chk("overflow sticky", 8'(rv[4]), 8'h01);
        rd(FTX_ADDR_STATUS, rv);
        chk("overflow cleared", 8'(rv[4]), 8'h00);
        $display("waveform test done");
    endtask : t_wave
    task results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        RESETN = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 7'h00;
        WDATA = 8'h00;
        RX_DATA = 1'b0;
        PLL_LOCK = 1'b0;
        repeat (12) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        PLL_LOCK <= 1'b1;
        t_regs();
        t_amp();
        t_divset();
        t_lock();
        t_wave();
        results();
    end
endmodule : tb_fsk_tx_modulation_control
